// [bench/pct_regs_test.sv]
// Purpose: Self-checking bench for the program control and timer registers.
// Assumes: Read data and its valid strobe appear one cycle after the read strobe.
// Notes:   Random words come from a fixed-seed shift register, so runs repeat.
`timescale 1ns/1ns
module pct_regs_test;
  import pct_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        fetch_advance;
  logic        fetch_jump;
  logic [19:0] jump_addr;
  logic [15:0] instr_data;
  logic        intr_taken;
  logic        branch_taken;
  logic        prefetch_load;
  logic [15:0] prefetch_word;
  logic        opcode_advance;
  logic        addr_advance;
  logic        timer_tick_a;
  logic        timer_tick_b;
  logic [3:0]  io_sel;
  logic        io_rd;
  logic        io_wr;
  logic [15:0] io_wdata;
  logic [15:0] io_rdata;
  logic        io_rvalid;
  logic [19:0] fetch_addr;
  logic [15:0] exec_word;
  logic [15:0] current_opcode;
  logic        timeout_pend_a;
  logic        timeout_pend_b;
  logic [31:0] rnd;
  logic [19:0] ja;
  logic [15:0] w1;
  int          err_total;
  int          checks_done;

  pct_regs u_dut (.mclk(mclk), .rst_n(rst_n), .fetch_advance(fetch_advance),
    .fetch_jump(fetch_jump), .jump_addr(jump_addr), .instr_data(instr_data),
    .intr_taken(intr_taken), .branch_taken(branch_taken), .prefetch_load(prefetch_load),
    .prefetch_word(prefetch_word), .opcode_advance(opcode_advance),
    .addr_advance(addr_advance), .timer_tick_a(timer_tick_a), .timer_tick_b(timer_tick_b),
    .io_sel(io_sel), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .fetch_addr(fetch_addr),
    .exec_word(exec_word), .current_opcode(current_opcode),
    .timeout_pend_a(timeout_pend_a), .timeout_pend_b(timeout_pend_b));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // A 20-bit address reads back as a low word and a high word.
  function automatic logic [15:0] addr_part(input logic [19:0] a, input bit hi);
    return hi ? {12'h000, a[19:16]} : a[15:0];
  endfunction

  task automatic complete_run();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [3:0] s, input logic [15:0] exp);
    @(posedge mclk);
    io_sel <= s;
    io_rd  <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1;
    check({19'h00000, io_rvalid}, 20'h00001, "read valid");
    check({4'h0, io_rdata}, {4'h0, exp}, "read data");
  endtask

  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge mclk);
    io_sel   <= s;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask

  // Bits: 0 advance, 1 jump, 2 interrupt, 3 branch, 4 prefetch, 5 opcode, 6 address.
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk);
    {addr_advance, opcode_advance, prefetch_load, branch_taken, intr_taken, fetch_jump,
     fetch_advance} <= m;
    @(posedge mclk);
    {addr_advance, opcode_advance, prefetch_load, branch_taken, intr_taken, fetch_jump,
     fetch_advance} <= 7'h00;
    #1;
  endtask

  task automatic timer_run(input bit b);
    logic [3:0] sel;
    sel = b ? SEL_TMR_B : SEL_TMR_A;
    wr(sel, 16'hfffd);
    rd(sel, 16'hfffd);
    wr(SEL_TMR_CTL, b ? 16'h0004 : 16'h0001);
    rd(SEL_TMR_CTL, b ? 16'h0002 : 16'h0001);
    @(posedge mclk);
    if (b) timer_tick_b <= 1'b1; else timer_tick_a <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check({18'h0, timeout_pend_b, timeout_pend_a}, 20'h0, "early timeout");
    @(posedge mclk);
    #1;
    check({18'h0, timeout_pend_b, timeout_pend_a}, b ? 20'h2 : 20'h1, "timeout bit");
    @(posedge mclk);
    {timer_tick_b, timer_tick_a} <= 2'b00;
    #1;
    check({18'h0, timeout_pend_b, timeout_pend_a}, 20'h0, "timeout width");
    wr(SEL_TMR_CTL, b ? 16'h0008 : 16'h0002);
    rd(sel, 16'h0001);
    @(posedge mclk);
    if (b) timer_tick_b <= 1'b1; else timer_tick_a <= 1'b1;
    repeat (3) @(posedge mclk);
    {timer_tick_b, timer_tick_a} <= 2'b00;
    rd(sel, 16'h0001);
    rd(SEL_TMR_CTL, 16'h0000);
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial
  begin
    repeat (3000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  initial
  begin
    err_total = 0;
    checks_done = 0;
    rnd = 32'h666e;
    rst_n = 1'b0;
    {fetch_advance, fetch_jump, intr_taken, branch_taken, prefetch_load} = 5'h00;
    {opcode_advance, addr_advance, timer_tick_a, timer_tick_b, io_rd, io_wr} = 6'h00;
    jump_addr = 20'h00000;
    instr_data = 16'h0000;
    prefetch_word = 16'h0000;
    io_sel = 4'h0;
    io_wdata = 16'h0000;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int s = 0; s < 10; s++)
      rd(s[3:0], 16'h0000);
    rd(4'hf, 16'h0000);
    // Jump, then two fetches: the first word reaches the execute latch.
    rnd = lfsr_next(rnd);
    ja = rnd[19:0];
    w1 = rnd[31:16];
    jump_addr <= ja;
    pulse(7'h02);
    instr_data <= w1;
    pulse(7'h01);
    instr_data <= ~w1;
    pulse(7'h01);
    check({4'h0, exec_word}, {4'h0, w1}, "execute latch");
    check(fetch_addr, ja + 20'h00002, "fetch address");
    rd(SEL_FETCH_LO, addr_part(ja + 20'h00002, 1'b0));
    rd(SEL_FETCH_HI, addr_part(ja + 20'h00002, 1'b1));
    pulse(7'h08);
    rd(SEL_SAVE_LO, addr_part(ja + 20'h00002, 1'b0));
    rd(SEL_SAVE_HI, addr_part(ja + 20'h00002, 1'b1));
    // Interrupt and jump together: the save keeps the address before the jump.
    // One more fetch first, so the save must differ from the earlier one.
    pulse(7'h01);
    jump_addr <= ~ja;
    pulse(7'h06);
    wr(SEL_SAVE_LO, ~rnd[15:0]);
    rd(SEL_SAVE_LO, addr_part(ja + 20'h00003, 1'b0));
    check(fetch_addr, ~ja, "jump address");
    pulse(7'h04);
    rd(SEL_SAVE_HI, addr_part(~ja, 1'b1));
    // Prefetch holder versus current opcode.
    prefetch_word <= w1;
    pulse(7'h10);
    rd(SEL_PREFETCH, w1);
    pulse(7'h20);
    check({4'h0, current_opcode}, {4'h0, w1}, "current opcode");
    prefetch_word <= ~w1;
    pulse(7'h10);
    check({4'h0, current_opcode}, {4'h0, w1}, "opcode kept");
    rd(SEL_PREFETCH, ~w1);
    rd(SEL_CUR_OP, w1);
    // Current opcode address with random values and the all-ones corner.
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr_next(rnd);
      w1 = (i == 0) ? 16'hffff : rnd[15:0];
      wr(SEL_CUR_ADDR, w1);
      rd(SEL_CUR_ADDR, w1);
      pulse(7'h40);
      rd(SEL_CUR_ADDR, w1 + 16'h0001);
    end
    timer_run(1'b0);
    timer_run(1'b1);
    complete_run();
  end
endmodule

// [design/pct_fetch_latch.sv]
// Purpose: Two-stage fetched-word latch for overlapping fetch and execute.
// Assumes: Capture comes once per fetch; advance moves the word to execute.
// Notes:   Primary takes memory data; secondary feeds execution.
`timescale 1ns/1ns
module pct_fetch_latch
  import pct_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             capture,
  input  wire logic [WIDTH-1:0] mem_data,
  output logic      [WIDTH-1:0] primary,
  output logic      [WIDTH-1:0] secondary
);
  if (WIDTH != WORD_W)
  begin : gen_width_check
    $error("pct_fetch_latch width must match the word width");
  end
  logic [WIDTH-1:0] pri_q, pri_d, sec_q, sec_d;

  // Both stages shift together so the next word arrives while one executes.
  always_comb
  begin
    pri_d = pri_q;
    sec_d = sec_q;
    if (capture)
    begin
      pri_d = mem_data;
      sec_d = pri_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pri_q <= WORD_RESET;
      sec_q <= WORD_RESET;
    end
    else
    begin
      pri_q <= pri_d;
      sec_q <= sec_d;
    end
  end

  assign primary   = pri_q;
  assign secondary = sec_q;

  chk_latch_shift: assert property (@(posedge mclk) disable iff (!rst_n)
    capture |=> (sec_q == $past(pri_q) && pri_q == $past(mem_data)))
    else $error("fetch latches did not shift");
endmodule

// [design/pct_pkg.sv]
// Purpose: Shared constants for the program control and timer register block.
// Assumes: One processor clock, synchronous active-low reset.
// Notes:   Register selects are the codes of the native I/O instruction.
package pct_pkg;
  localparam int FETCH_W = 20;
  localparam int WORD_W  = 16;
  localparam int SEL_W   = 4;
  // ----------------------------------------------------------------------
  // I/O select codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] SEL_FETCH_LO = 4'h0;
  localparam logic [3:0] SEL_FETCH_HI = 4'h1;
  localparam logic [3:0] SEL_SAVE_LO  = 4'h2;
  localparam logic [3:0] SEL_SAVE_HI  = 4'h3;
  localparam logic [3:0] SEL_PREFETCH = 4'h4;
  localparam logic [3:0] SEL_CUR_OP   = 4'h5;
  localparam logic [3:0] SEL_CUR_ADDR = 4'h6;
  localparam logic [3:0] SEL_TMR_A    = 4'h7;
  localparam logic [3:0] SEL_TMR_B    = 4'h8;
  localparam logic [3:0] SEL_TMR_CTL  = 4'h9;
  // ----------------------------------------------------------------------
  // Timer control word fields, reset values, terminal count and fetch step
  // ----------------------------------------------------------------------
  localparam int TCTL_START_A = 0;
  localparam int TCTL_HALT_A  = 1;
  localparam int TCTL_START_B = 2;
  localparam int TCTL_HALT_B  = 3;
  localparam logic [15:0] TMR_RESET   = 16'h0000;
  localparam logic [15:0] TMR_TERM    = 16'hffff;
  localparam logic [19:0] FETCH_RESET = 20'h00000;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [19:0] FETCH_STEP  = 20'h00001;
endpackage

// [design/pct_regs.sv]
// Purpose: Program sequencing registers and interval timers of the core.
// Assumes: The native I/O instruction presents a select code with a one-cycle
//          read or write strobe; read data is registered one cycle later.
// Notes:   The saved fetch address is overwritten by every save event.
// Behaviour
// - Fetched word register is two 16-bit latches, primary and secondary.
// - Interrupt or branch copies the fetch address into the save register.
// - Saved fetch address is read only through the native input instruction.
// - Prefetched next emulated instruction word held in 16-bit register.
// - Prefetch holder is readable by the native I/O instruction.
// - Current emulated instruction held apart from the prefetched word.
// - A 16-bit register holds the current emulated instruction's address.
// - Current instruction address register is readable and writable.
// - Two independent 16-bit up counters serve as interval timers.
// - I/O can start, halt, read and load each timer; halted holds.
// - Timeout when a counter wraps from all ones to zero.
// - Each timeout sets that timer's own pending interrupt bit.
// - 20-bit fetch address goes out separately from instruction data.
`timescale 1ns/1ns
module pct_regs
(
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       fetch_advance,
  input  wire logic                       fetch_jump,
  input  wire logic [pct_pkg::FETCH_W-1:0] jump_addr,
  input  wire logic [pct_pkg::WORD_W-1:0]  instr_data,
  input  wire logic                       intr_taken,
  input  wire logic                       branch_taken,
  input  wire logic                       prefetch_load,
  input  wire logic [pct_pkg::WORD_W-1:0]  prefetch_word,
  input  wire logic                       opcode_advance,
  input  wire logic                       addr_advance,
  input  wire logic                       timer_tick_a,
  input  wire logic                       timer_tick_b,
  input  wire logic [pct_pkg::SEL_W-1:0]   io_sel,
  input  wire logic                       io_rd,
  input  wire logic                       io_wr,
  input  wire logic [pct_pkg::WORD_W-1:0]  io_wdata,
  output logic      [pct_pkg::WORD_W-1:0]  io_rdata,
  output logic                            io_rvalid,
  output logic      [pct_pkg::FETCH_W-1:0] fetch_addr,
  output logic      [pct_pkg::WORD_W-1:0]  exec_word,
  output logic      [pct_pkg::WORD_W-1:0]  current_opcode,
  output logic                            timeout_pend_a,
  output logic                            timeout_pend_b
);
  import pct_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [FETCH_W-1:0] fac_q, fac_d;
  logic [FETCH_W-1:0] sav_q, sav_d;
  logic [WORD_W-1:0]  pre_q, pre_d;
  logic [WORD_W-1:0]  cop_q, cop_d;
  logic [WORD_W-1:0]  cad_q, cad_d;
  logic [WORD_W-1:0]  rd_q, rd_d;
  logic               rv_q, rv_d;
  logic [WORD_W-1:0]  pri_word, sec_word;
  logic [WORD_W-1:0]  tmr_cnt [2];
  logic [1:0]         tmr_run, tmr_to;
  logic [1:0]         tmr_start, tmr_halt, tmr_load, tmr_tick;
  logic               wr_ctl, wr_addr;

  // ----------------------------------------------------------------------
  // Fetch path
  // ----------------------------------------------------------------------
  pct_fetch_latch #(.WIDTH(WORD_W)) u_latch (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .capture   (fetch_advance),
    .mem_data  (instr_data),
    .primary   (pri_word),
    .secondary (sec_word)
  );

  // The jump wins, so a taken branch never also steps past its target.
  always_comb
  begin
    fac_d = fac_q;
    if (fetch_jump) fac_d = jump_addr;
    else if (fetch_advance) fac_d = fac_q + FETCH_STEP;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fac_q <= FETCH_RESET;
    end
    else
    begin
      fac_q <= fac_d;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch address save
  // ----------------------------------------------------------------------
  always_comb
  begin
    sav_d = sav_q;
    // The save sees the address before this cycle's jump, which is the
    // return point the handler needs; a later event overwrites it.
    if (intr_taken || branch_taken) sav_d = fac_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sav_q <= FETCH_RESET;
    end
    else
    begin
      sav_q <= sav_d;
    end
  end

  // ----------------------------------------------------------------------
  // Emulated instruction registers
  // ----------------------------------------------------------------------
  assign wr_addr = io_wr && (io_sel == SEL_CUR_ADDR);

  always_comb
  begin
    pre_d = pre_q;
    cop_d = cop_q;
    cad_d = cad_q;
    if (prefetch_load) pre_d = prefetch_word;
    if (opcode_advance) cop_d = pre_q;
    // Software owns the address when it writes; a same-cycle step is lost.
    if (wr_addr) cad_d = io_wdata;
    else if (addr_advance) cad_d = cad_q + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pre_q <= WORD_RESET;
      cop_q <= WORD_RESET;
      cad_q <= WORD_RESET;
    end
    else
    begin
      pre_q <= pre_d;
      cop_q <= cop_d;
      cad_q <= cad_d;
    end
  end

  // ----------------------------------------------------------------------
  // Interval timers
  // ----------------------------------------------------------------------
  assign wr_ctl    = io_wr && (io_sel == SEL_TMR_CTL);
  assign tmr_start = wr_ctl ? {io_wdata[TCTL_START_B], io_wdata[TCTL_START_A]} : 2'b00;
  assign tmr_halt  = wr_ctl ? {io_wdata[TCTL_HALT_B], io_wdata[TCTL_HALT_A]} : 2'b00;
  assign tmr_load  = {io_wr && (io_sel == SEL_TMR_B), io_wr && (io_sel == SEL_TMR_A)};
  assign tmr_tick  = {timer_tick_b, timer_tick_a};

  // Index 0 is the first interval counter and index 1 the second.
  for (genvar t = 0; t < 2; t++)
  begin : gen_tmr
    pct_timer #(.WIDTH(WORD_W)) u_tmr (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .start    (tmr_start[t]),
      .halt     (tmr_halt[t]),
      .load     (tmr_load[t]),
      .load_val (io_wdata),
      .tick     (tmr_tick[t]),
      .count    (tmr_cnt[t]),
      .running  (tmr_run[t]),
      .timeout  (tmr_to[t])
    );
  end

  // ----------------------------------------------------------------------
  // I/O read port
  // ----------------------------------------------------------------------
  // Every read is answered one cycle later; the data then holds until the next read.
  always_comb
  begin
    rd_d = rd_q;
    rv_d = io_rd;
    if (io_rd)
    begin
      if (io_sel == SEL_FETCH_LO) rd_d = fac_q[WORD_W-1:0];
      else if (io_sel == SEL_FETCH_HI) rd_d = {12'h000, fac_q[FETCH_W-1:WORD_W]};
      else if (io_sel == SEL_SAVE_LO) rd_d = sav_q[WORD_W-1:0];
      else if (io_sel == SEL_SAVE_HI) rd_d = {12'h000, sav_q[FETCH_W-1:WORD_W]};
      else if (io_sel == SEL_PREFETCH) rd_d = pre_q;
      else if (io_sel == SEL_CUR_OP) rd_d = cop_q;
      else if (io_sel == SEL_CUR_ADDR) rd_d = cad_q;
      else if (io_sel == SEL_TMR_A) rd_d = tmr_cnt[0];
      else if (io_sel == SEL_TMR_B) rd_d = tmr_cnt[1];
      else if (io_sel == SEL_TMR_CTL) rd_d = {14'h0, tmr_run};
      else rd_d = WORD_RESET;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_q <= WORD_RESET;
      rv_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
      rv_q <= rv_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign fetch_addr     = fac_q;
  assign exec_word      = sec_word;
  assign current_opcode = cop_q;
  // Pending bits are pulses; the interrupt controller latches them.
  assign timeout_pend_a = tmr_to[0];
  assign timeout_pend_b = tmr_to[1];
  assign io_rdata       = rd_q;
  assign io_rvalid      = rv_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_jump_load: assert property (@(posedge mclk) disable iff (!rst_n)
    fetch_jump |=> (fetch_addr == $past(jump_addr)))
    else $error("fetch address jump lost");
  chk_fetch_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_FETCH_LO) |=> (io_rdata == $past(fac_q[WORD_W-1:0])))
    else $error("fetch address low read wrong");
  chk_fetch_hi_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_FETCH_HI) |=> (io_rdata == {12'h000, $past(fac_q[FETCH_W-1:WORD_W])}))
    else $error("fetch address high read wrong");
  chk_save_hi_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_SAVE_HI) |=> (io_rdata == {12'h000, $past(sav_q[FETCH_W-1:WORD_W])}))
    else $error("saved address high read wrong");
  chk_rvalid_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (io_rvalid == $past(io_rd)))
    else $error("read valid not a one-cycle answer");
  chk_pref_load: assert property (@(posedge mclk) disable iff (!rst_n)
    prefetch_load |=> (pre_q == $past(prefetch_word)))
    else $error("prefetch word not held");
  chk_pref_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !prefetch_load |=> (pre_q == $past(pre_q)))
    else $error("prefetch holder changed without load");
  chk_opcode_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !opcode_advance |=> (cop_q == $past(cop_q)))
    else $error("current opcode changed without advance");
  chk_addr_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (addr_advance && !wr_addr) |=> (cad_q == $past(cad_q) + 1'b1))
    else $error("current address did not step");
  chk_addr_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !(addr_advance || wr_addr) |=> (cad_q == $past(cad_q)))
    else $error("current address changed by itself");
  chk_addr_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_CUR_ADDR) |=> (io_rdata == $past(cad_q)))
    else $error("current address read wrong");
  chk_exec_word: assert property (@(posedge mclk) disable iff (!rst_n)
    fetch_advance |=> (exec_word == $past(pri_word)))
    else $error("execute word not taken from primary latch");
  chk_timer_b_pend: assert property (@(posedge mclk) disable iff (!rst_n)
    (tmr_run[1] && timer_tick_b && !tmr_load[1] && tmr_cnt[1] == TMR_TERM) |=> timeout_pend_b)
    else $error("timer b timeout not flagged");
  chk_ctl_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_TMR_CTL) |=> (io_rdata == {14'h0, $past(tmr_run)}))
    else $error("timer control read wrong");
  chk_tmr_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_TMR_A) |=> (io_rdata == $past(tmr_cnt[0])))
    else $error("timer a read wrong");
  chk_save_on_event: assert property (@(posedge mclk) disable iff (!rst_n)
    (intr_taken || branch_taken) |=> (sav_q == $past(fac_q)))
    else $error("fetch address not saved");
  chk_save_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    !(intr_taken || branch_taken) |=> (sav_q == $past(sav_q)))
    else $error("saved address changed without event");
  chk_save_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_SAVE_LO) |=> (io_rvalid && io_rdata == $past(sav_q[15:0])))
    else $error("saved address read wrong");
  chk_pref_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_rd && io_sel == SEL_PREFETCH) |=> (io_rdata == $past(pre_q)))
    else $error("prefetch read wrong");
  chk_opcode_take: assert property (@(posedge mclk) disable iff (!rst_n)
    opcode_advance |=> (cop_q == $past(pre_q)))
    else $error("current opcode not taken from prefetch");
  chk_addr_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (io_wr && io_sel == SEL_CUR_ADDR) |=> (cad_q == $past(io_wdata)))
    else $error("current address write lost");
  chk_timer_pend: assert property (@(posedge mclk) disable iff (!rst_n)
    (tmr_run[0] && timer_tick_a && !tmr_load[0] && tmr_cnt[0] == TMR_TERM) |=> timeout_pend_a)
    else $error("timer a timeout not flagged");
  chk_fetch_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (fetch_advance && !fetch_jump) |=> (fetch_addr == $past(fac_q) + FETCH_STEP))
    else $error("fetch address did not step");
endmodule

// [design/pct_timer.sv]
// Purpose: One 16-bit up-counting interval timer.
// Assumes: Start, halt and load come as one-cycle pulses.
// Notes:   Load wins over tick; the timer keeps running after a timeout.
`timescale 1ns/1ns
module pct_timer
  import pct_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             halt,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             tick,
  output logic      [WIDTH-1:0] count,
  output logic                  running,
  output logic                  timeout
);
  if (WIDTH != WORD_W)
  begin : gen_width_check
    $error("pct_timer width must match the word width");
  end
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic             run_q, run_d;
  logic             to_q, to_d;

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    to_d  = 1'b0;
    if (start) run_d = 1'b1;
    else if (halt) run_d = 1'b0;
    if (load) cnt_d = load_val;
    else if (run_q && tick)
    begin
      cnt_d = cnt_q + 1'b1;
      to_d  = (cnt_q == TMR_TERM);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_q <= TMR_RESET;
      run_q <= 1'b0;
      to_q  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      to_q  <= to_d;
    end
  end

  assign count   = cnt_q;
  assign running = run_q;
  assign timeout = to_q;

  chk_wrap_timeout: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_q && tick && !load && cnt_q == TMR_TERM) |=> (to_q && cnt_q == TMR_RESET))
    else $error("wrap did not raise timeout");
  chk_halt_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (!run_q && !load) |=> (cnt_q == $past(cnt_q)))
    else $error("halted timer changed");
  chk_tick_adds: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_q && tick && !load) |=> (cnt_q == $past(cnt_q) + 1'b1))
    else $error("running timer did not count");
endmodule
